/* File: rtl/ccr_router.sv */
// Configuration cycle router: host I/O to configuration cycles.
// Assumes a host I/O request is held for one cycle; cycle issue is a
// one-cycle request pulse toward the primary, graphics, own, pass-through or abort engines.
`timescale 1ns/1ps
`default_nettype none
module ccr_router (
  input  wire logic                CLK,
  input  wire logic                RST_B,
  // Host I/O request
  input  wire logic                IO_REQ,
  input  wire logic                IO_WRITE,
  input  wire logic [15:0]         IO_ADDR,
  input  wire logic [3:0]          IO_BE,
  input  wire logic [31:0]         IO_WDATA,
  output logic                     IO_ACK,
  output logic      [31:0]         IO_RDATA,
  output logic                     IO_CLAIM,
  // Virtual bridge bus numbers
  input  wire logic [7:0]          SECONDARY_BUS_VALUE,
  input  wire logic [7:0]          SUBORDINATE_BUS_VALUE,
  // Outbound configuration cycle
  output logic                     PRI_CFG_REQ,
  output logic                     GFX_CFG_REQ,
  output logic                     OWN_CFG_REQ,
  output logic                     IO_PASS_REQ,
  output logic                     CFG_ABORT,
  output logic                     CFG_WRITE,
  output logic                     CFG_TYPE1,
  output logic      [31:0]         CFG_ADDR,
  output logic      [3:0]          CFG_BE,
  output logic      [31:0]         CFG_WDATA
);
  import ccr_pkg::*;

  // ==========================================================
  // Address select register
  logic [31:0] config_address_select;
  logic [31:0] next_config_address_select;
  logic        hit_addr;
  logic        hit_addr_dword;
  logic        hit_data;
  logic        config_access_enable;

  assign hit_addr       = IO_REQ && (IO_ADDR == CCR_ADDR_SELECT_IO);
  assign hit_addr_dword = hit_addr && (IO_BE == CCR_ALL_BYTES);
  assign hit_data       = IO_REQ && (IO_ADDR == CCR_DATA_WINDOW_IO);
  assign config_access_enable = config_address_select[CCR_ENABLE_BIT];

  // Dword write loads; reserved bits 30:24 and 1:0 kept zero
  always_comb begin
    next_config_address_select = config_address_select;
    if (hit_addr_dword && IO_WRITE)
      next_config_address_select = {IO_WDATA[31], 7'h00, IO_WDATA[23:2], 2'h0};
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      config_address_select <= CCR_ADDR_RESET;
    end else begin
      config_address_select <= next_config_address_select;
    end
  end

  // ==========================================================
  // Routing decode
  ccr_dest_t  route;
  logic [31:0] route_addr;
  logic        route_type1;

  ccr_decode u_decode (
    .addr_select           (config_address_select),
    .secondary_bus_value   (SECONDARY_BUS_VALUE),
    .subordinate_bus_value (SUBORDINATE_BUS_VALUE),
    .dest                  (route),
    .cycle_addr            (route_addr),
    .type1                 (route_type1)
  );

  // ==========================================================
  // Cycle issue: at most one registered request per host access
  ccr_dest_t   dest;
  ccr_dest_t   next_dest;
  logic        next_write;
  logic        next_type1;
  logic [31:0] next_addr;
  logic [3:0]  next_be;
  logic [31:0] next_wdata;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        ack;
  logic        next_ack;

  // Only the 0cf8/0cfc pair exists; no alternate mechanism
  always_comb begin
    next_dest  = CCR_DEST_NONE;
    next_write = CFG_WRITE;
    next_type1 = CFG_TYPE1;
    next_addr  = CFG_ADDR;
    next_be    = CFG_BE;
    next_wdata = CFG_WDATA;
    next_rdata = rdata;
    next_ack   = 1'b0;
    if (hit_addr_dword) begin
      next_ack = 1'b1;
      if (!IO_WRITE)
        next_rdata = config_address_select;
    end else if (hit_addr) begin
      // Byte or word reference passes through as plain I/O
      next_dest  = CCR_DEST_IOPASS;
      next_write = IO_WRITE;
      next_addr  = {16'h0000, IO_ADDR};
      next_be    = IO_BE;
      next_wdata = IO_WDATA;
      next_type1 = 1'b0;
    end else if (hit_data && config_access_enable) begin
      next_dest  = route;
      next_write = IO_WRITE;
      next_addr  = route_addr;
      next_type1 = route_type1;
      next_be    = IO_BE; // Any byte lanes
      next_wdata = IO_WDATA;
    end else if (hit_data) begin
      // Disabled window passes through as plain I/O
      next_dest  = CCR_DEST_IOPASS;
      next_write = IO_WRITE;
      next_addr  = {16'h0000, IO_ADDR};
      next_be    = IO_BE;
      next_wdata = IO_WDATA;
      next_type1 = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dest      <= CCR_DEST_NONE;
      CFG_WRITE <= 1'b0;
      CFG_TYPE1 <= 1'b0;
      CFG_ADDR  <= 32'h0000_0000;
      CFG_BE    <= 4'h0;
      CFG_WDATA <= 32'h0000_0000;
      rdata     <= 32'h0000_0000;
      ack       <= 1'b0;
    end else begin
      dest      <= next_dest;
      CFG_WRITE <= next_write;
      CFG_TYPE1 <= next_type1;
      CFG_ADDR  <= next_addr;
      CFG_BE    <= next_be;
      CFG_WDATA <= next_wdata;
      rdata     <= next_rdata;
      ack       <= next_ack;
    end
  end

  // Decoded request strobes
  assign PRI_CFG_REQ = (dest == CCR_DEST_PRI);
  assign GFX_CFG_REQ = (dest == CCR_DEST_GFX);
  assign OWN_CFG_REQ = (dest == CCR_DEST_OWN);
  assign IO_PASS_REQ = (dest == CCR_DEST_IOPASS);
  assign CFG_ABORT   = (dest == CCR_DEST_ABORT);
  assign IO_ACK      = ack;
  assign IO_RDATA    = rdata;
  assign IO_CLAIM    = hit_addr_dword;

  // ==========================================================
  // Check helpers: select fields seen at a data window hit
  logic [7:0] chk_bus;
  logic [4:0] chk_dev;
  logic       chk_cfg;
  logic       chk_sec_hit;

  // Enabled window hit, and a hit aimed at the secondary bus itself
  assign chk_bus     = config_address_select[CCR_BUS_MSB:CCR_BUS_LSB];
  assign chk_dev     = config_address_select[CCR_DEV_MSB:CCR_DEV_LSB];
  assign chk_cfg     = hit_data && config_access_enable;
  assign chk_sec_hit = chk_cfg && (chk_bus != 8'h00) && (chk_bus == SECONDARY_BUS_VALUE) &&
                       (chk_bus <= SUBORDINATE_BUS_VALUE);

  // ==========================================================
  // Checks
  // Dword write loads the enable bit
  a_addr_load: assert property (@(posedge CLK) disable iff (!RST_B)
    hit_addr_dword && IO_WRITE |=> config_address_select[31] == $past(IO_WDATA[31]))
    else $error("address select not loaded");
  // Partial select access passes and leaves the register alone
  a_partial_pass: assert property (@(posedge CLK) disable iff (!RST_B)
    hit_addr && !hit_addr_dword |=> IO_PASS_REQ && config_address_select == $past(config_address_select))
    else $error("partial address access not passed");
  // Disabled window never makes a configuration cycle
  a_disabled_block: assert property (@(posedge CLK) disable iff (!RST_B)
    hit_data && !config_access_enable |=> !PRI_CFG_REQ && !GFX_CFG_REQ && !OWN_CFG_REQ)
    else $error("config cycle while disabled");
  // Cycle direction follows the host access
  a_dir_match: assert property (@(posedge CLK) disable iff (!RST_B)
    hit_data && config_access_enable |=> (CFG_WRITE == $past(IO_WRITE)) && !IO_PASS_REQ)
    else $error("cycle direction mismatch");
  // Type 1 image has code 01 low and zero high byte
  a_type1_low: assert property (@(posedge CLK) disable iff (!RST_B)
    (PRI_CFG_REQ || GFX_CFG_REQ) && CFG_TYPE1 |-> CFG_ADDR[1:0] == 2'h1 && CFG_ADDR[31:24] == 8'h00)
    else $error("type 1 address low bits wrong");
  // Primary Type 0 raises at most one foreign select
  a_pri_onehot: assert property (@(posedge CLK) disable iff (!RST_B)
    PRI_CFG_REQ && !CFG_TYPE1 |-> $onehot0(CFG_ADDR[31:11]) && !CFG_ADDR[11] && !CFG_ADDR[12])
    else $error("primary select not one-hot");
  // Graphics Type 0 raises at most one select
  a_gfx_onehot: assert property (@(posedge CLK) disable iff (!RST_B)
    GFX_CFG_REQ && !CFG_TYPE1 |-> $onehot0(CFG_ADDR[31:16]) && CFG_ADDR[15:11] == 5'h00)
    else $error("graphics select not one-hot");
  // Bus zero stays off the graphics port
  a_bus0_route: assert property (@(posedge CLK) disable iff (!RST_B)
    hit_data && config_access_enable && config_address_select[23:16] == 8'h00
      |=> !GFX_CFG_REQ && !CFG_TYPE1)
    else $error("bus zero misrouted");
  // Nonzero function aimed at our devices aborts
  a_func_abort: assert property (@(posedge CLK) disable iff (!RST_B)
    hit_data && config_access_enable && config_address_select[23:12] == 12'h000
      && config_address_select[10:8] != 3'h0 |=> CFG_ABORT)
    else $error("foreign function not aborted");
  // Ports other than the pair leave the acknowledge and every request strobe quiet
  a_idle_quiet: assert property (@(posedge CLK) disable iff (!RST_B)
    !hit_addr && !hit_data |=> !IO_ACK && !PRI_CFG_REQ && !GFX_CFG_REQ
      && !OWN_CFG_REQ && !IO_PASS_REQ && !CFG_ABORT)
    else $error("request on an unmapped port");
  // Acknowledge only answers a dword select access
  a_ack_cause: assert property (@(posedge CLK) disable iff (!RST_B)
    IO_ACK |-> $past(hit_addr_dword))
    else $error("acknowledge without dword select access");
  // Dword select access is acknowledged, never passed on
  a_dword_ack: assert property (@(posedge CLK) disable iff (!RST_B)
    hit_addr_dword |=> IO_ACK && !IO_PASS_REQ)
    else $error("dword select access not acknowledged");
  // Dword read returns the stored select value
  a_read_select: assert property (@(posedge CLK) disable iff (!RST_B)
    hit_addr_dword && !IO_WRITE |=> IO_RDATA == $past(config_address_select))
    else $error("select read data wrong");
  // Nonzero bus below secondary goes to primary as Type 1
  a_below_sec: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_cfg && (chk_bus != 8'h00) && (chk_bus < SECONDARY_BUS_VALUE) |=> PRI_CFG_REQ && CFG_TYPE1)
    else $error("bus below secondary misrouted");
  // Bus above subordinate goes to primary as Type 1
  a_above_sub: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_cfg && (chk_bus > SUBORDINATE_BUS_VALUE) |=> PRI_CFG_REQ && CFG_TYPE1)
    else $error("bus above subordinate misrouted");
  // Bus inside the span but past secondary is graphics Type 1
  a_span_type1: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_cfg && (chk_bus > SECONDARY_BUS_VALUE) && (chk_bus <= SUBORDINATE_BUS_VALUE)
      |=> GFX_CFG_REQ && CFG_TYPE1)
    else $error("bus behind secondary misrouted");
  // Bus equal to secondary is graphics Type 0
  a_sec_type0: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_sec_hit |=> GFX_CFG_REQ && !CFG_TYPE1)
    else $error("secondary bus misrouted");
  // Type 1 image copies bits 23:2 of the select value
  a_type1_copy: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_cfg |=> !CFG_TYPE1 || (CFG_ADDR[23:2] == $past(config_address_select[23:2])))
    else $error("type 1 address fields wrong");
  // Bus zero image carries function and register unchanged
  a_bus0_image: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_cfg && (chk_bus == 8'h00) |=> CFG_ADDR[10:0] == {$past(config_address_select[10:2]), 2'h0})
    else $error("bus zero register field wrong");
  // Graphics Type 0 image carries function and register unchanged
  a_gfx_image: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_sec_hit |=> CFG_ADDR[15:0] == {5'h00, $past(config_address_select[10:2]), 2'h0})
    else $error("graphics function field wrong");
  // Foreign device on bus zero raises its own select line
  a_pri_select: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_cfg && (chk_bus == 8'h00) && (chk_dev > CCR_VBRIDGE_DEV) && (chk_dev <= CCR_PRI_MAX_DEV)
      |=> PRI_CFG_REQ && (CFG_ADDR[31:11] == (21'h000001 << $past(chk_dev))))
    else $error("primary select line wrong");
  // Primary device past the last select raises none
  a_pri_beyond: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_cfg && (chk_bus == 8'h00) && (chk_dev > CCR_PRI_MAX_DEV)
      |=> PRI_CFG_REQ && (CFG_ADDR[31:11] == 21'h000000))
    else $error("primary select raised past last device");
  // Graphics device raises its own select line
  a_gfx_select: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_sec_hit && (chk_dev <= CCR_GFX_MAX_DEV) |=> CFG_ADDR[31:16] == (16'h0001 << $past(chk_dev)))
    else $error("graphics select line wrong");
  // Graphics device past the last select raises none
  a_gfx_beyond: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_sec_hit && (chk_dev > CCR_GFX_MAX_DEV) |=> GFX_CFG_REQ && (CFG_ADDR[31:16] == 16'h0000))
    else $error("graphics select raised past last device");
  // Own functions claim the cycle on the matching internal select
  a_own_select: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_cfg && (chk_bus == 8'h00) && (chk_dev <= CCR_VBRIDGE_DEV)
      && (config_address_select[10:8] == CCR_OWN_FUNC)
      |=> OWN_CFG_REQ && (CFG_ADDR[12:11] == ($past(chk_dev[0]) ? 2'h2 : 2'h1)))
    else $error("own function select wrong");
  // Byte lanes and write data pass to the cycle unchanged
  a_data_forward: assert property (@(posedge CLK) disable iff (!RST_B)
    hit_data |=> (CFG_BE == $past(IO_BE)) && (!CFG_WRITE || (CFG_WDATA == $past(IO_WDATA))))
    else $error("byte lanes or write data not forwarded");
  // Pass-through cycle carries the plain I/O address
  a_pass_image: assert property (@(posedge CLK) disable iff (!RST_B)
    (hit_addr && !hit_addr_dword) || (hit_data && !config_access_enable)
      |=> IO_PASS_REQ && !CFG_TYPE1 && (CFG_ADDR == {16'h0000, $past(IO_ADDR)}))
    else $error("pass-through address wrong");
  // Enabled window always becomes a configuration cycle
  a_window_map: assert property (@(posedge CLK) disable iff (!RST_B)
    chk_cfg |=> PRI_CFG_REQ || GFX_CFG_REQ || OWN_CFG_REQ || CFG_ABORT)
    else $error("enabled window access not mapped");
endmodule
`default_nettype wire

/* File: rtl/ccr_pkg.sv */
// Constants for the configuration cycle router.
// Assumes host I/O cycles arrive as synchronous single-cycle requests.
//
// Contract
// - Bus zero targets self or primary bus
// - Bus zero foreign device gives primary Type 0
// - Bus below secondary gives primary Type 1
// - Bus above secondary up to subordinate gives graphics Type 1
// - Bus equal secondary gives graphics Type 0
// - Type 1 carries device field on AD[15:11]
// - Own functions are devices 0 and 1
// - Function on AD[10:8]; nonzero own function aborts
// - Register field maps onto AD[7:2]
// - Enable bit maps data window to config
// - Data window takes 32/16/8-bit accesses
// - Only access mechanism one is supported
// - Each data access makes matching-direction cycle
// - Primary Type 0 one-hot select AD13..AD31
// - Primary device above 20 selects nothing
// - Graphics Type 0 one-hot select GAD16..GAD31
// - Graphics device above 15 selects nothing
// - Primary Type 1 address bits, low 01
// - Routing uses virtual bridge bus numbers
// - Nonzero bus outside span gives primary Type 1
// - Address register dword only at 0cf8
package ccr_pkg;
  localparam logic [15:0] CCR_ADDR_SELECT_IO = 16'h0cf8;
  localparam logic [15:0] CCR_DATA_WINDOW_IO = 16'h0cfc;
  localparam logic [31:0] CCR_ADDR_RESET     = 32'h0000_0000;
  localparam int CCR_ENABLE_BIT = 31;
  localparam int CCR_BUS_MSB    = 23;
  localparam int CCR_BUS_LSB    = 16;
  localparam int CCR_DEV_MSB    = 15;
  localparam int CCR_DEV_LSB    = 11;
  localparam int CCR_FUNC_MSB   = 10;
  localparam int CCR_FUNC_LSB   = 8;
  localparam int CCR_REG_MSB    = 7;
  localparam int CCR_REG_LSB    = 2;
  localparam logic [4:0] CCR_PRI_MAX_DEV = 5'h14;
  localparam logic [4:0] CCR_GFX_MAX_DEV = 5'h0f;
  localparam logic [4:0] CCR_HOST_DEV    = 5'h00;
  localparam logic [4:0] CCR_VBRIDGE_DEV = 5'h01;
  localparam logic [2:0] CCR_OWN_FUNC    = 3'h0;
  localparam logic [1:0] CCR_TYPE1_CODE  = 2'h1;
  localparam logic [1:0] CCR_TYPE0_CODE  = 2'h0;
  localparam logic [3:0] CCR_ALL_BYTES   = 4'hf;

  // Destination of one host access
  typedef enum logic [2:0] {
    CCR_DEST_NONE   = 3'b000,
    CCR_DEST_OWN    = 3'b001,
    CCR_DEST_PRI    = 3'b010,
    CCR_DEST_GFX    = 3'b011,
    CCR_DEST_ABORT  = 3'b100,
    CCR_DEST_IOPASS = 3'b101
  } ccr_dest_t;
endpackage

/* File: rtl/ccr_decode.sv */
// Combinational routing decode of the stored address select value.
// Assumes bus numbers from the virtual bridge are stable while used.
`timescale 1ns/1ps
`default_nettype none
module ccr_decode (
  input  wire logic [31:0]       addr_select,
  input  wire logic [7:0]        secondary_bus_value,
  input  wire logic [7:0]        subordinate_bus_value,
  output ccr_pkg::ccr_dest_t     dest,
  output logic      [31:0]       cycle_addr,
  output logic                   type1
);
  import ccr_pkg::*;

  logic [7:0] target_bus_field;
  logic [4:0] target_device_field;
  logic [2:0] target_function_field;
  logic [5:0] target_register_field;
  logic       in_span;

  // Fields of the stored select value
  assign target_bus_field      = addr_select[CCR_BUS_MSB:CCR_BUS_LSB];
  assign target_device_field   = addr_select[CCR_DEV_MSB:CCR_DEV_LSB];
  assign target_function_field = addr_select[CCR_FUNC_MSB:CCR_FUNC_LSB];
  assign target_register_field = addr_select[CCR_REG_MSB:CCR_REG_LSB];
  // Inclusive secondary..subordinate span
  assign in_span = (target_bus_field >= secondary_bus_value) &&
                   (target_bus_field <= subordinate_bus_value);

  // Route and address phase image
  always_comb begin
    dest       = CCR_DEST_PRI;
    type1      = 1'b0;
    cycle_addr = 32'h0000_0000;
    if (target_bus_field == 8'h00) begin
      cycle_addr[10:2] = {target_function_field, target_register_field};
      if (target_device_field == CCR_HOST_DEV || target_device_field == CCR_VBRIDGE_DEV) begin
        // Own functions; idsel on AD11/AD12 used internally
        cycle_addr[5'd11 + target_device_field] = 1'b1;
        dest = (target_function_field == CCR_OWN_FUNC) ? CCR_DEST_OWN : CCR_DEST_ABORT;
      end else begin
        dest = CCR_DEST_PRI;
        if (target_device_field <= CCR_PRI_MAX_DEV)
          cycle_addr[5'd11 + target_device_field] = 1'b1;
        // Beyond device 20 no select: master abort on bus
      end
    end else if (!in_span) begin
      // Covers bus below secondary and above subordinate
      dest       = CCR_DEST_PRI;
      type1      = 1'b1;
      cycle_addr = {8'h00, addr_select[23:2], CCR_TYPE1_CODE};
    end else if (target_bus_field == secondary_bus_value) begin
      dest = CCR_DEST_GFX;
      cycle_addr[10:2] = {target_function_field, target_register_field};
      if (target_device_field <= CCR_GFX_MAX_DEV)
        cycle_addr[5'd16 + target_device_field] = 1'b1;
      // Beyond device 15 no select
    end else begin
      dest       = CCR_DEST_GFX;
      type1      = 1'b1;
      cycle_addr = {8'h00, addr_select[23:2], CCR_TYPE1_CODE};
    end
  end
endmodule
`default_nettype wire

/* File: bench/ccr_target_model.sv */
// Far-side configuration target model: notes which engine took each cycle.
// Assumes request pulses last one cycle and are sampled on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module ccr_target_model (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         pri_req,
  input  wire logic         gfx_req,
  input  wire logic         own_req,
  input  wire logic         pass_req,
  input  wire logic         abort,
  output ccr_pkg::ccr_dest_t kind,
  output int                count
);
  import ccr_pkg::*;
  // ==========================================================
  // Capture; more than one engine at once records no target
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      kind  <= CCR_DEST_NONE;
      count <= 0;
    end else if (pri_req | gfx_req | own_req | pass_req | abort) begin
      count <= count + 1;
      case ({pri_req, gfx_req, own_req, pass_req, abort})
        5'h10:   kind <= CCR_DEST_PRI;
        5'h08:   kind <= CCR_DEST_GFX;
        5'h04:   kind <= CCR_DEST_OWN;
        5'h02:   kind <= CCR_DEST_IOPASS;
        5'h01:   kind <= CCR_DEST_ABORT;
        default: kind <= CCR_DEST_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: bench/ccr_router_tb.sv */
// Self-checking bench for the configuration cycle router.
// Assumes the one-cycle answer latency of the router's host side.
`timescale 1ns/1ps
`default_nettype none
module ccr_router_tb;
  import ccr_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        io_req = 1'b0;
  logic        io_write = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [3:0]  io_be = 4'h0;
  logic [31:0] io_wdata = 32'h0000_0000;
  logic [7:0]  sec_bus = 8'h04;
  logic [7:0]  sub_bus = 8'h06;
  logic        io_ack, io_claim, pri_req, gfx_req, own_req, pass_req;
  logic        cfg_abort, cfg_write, cfg_type1, ack, claim;
  logic        dir = 1'b0;
  logic [31:0] io_rdata, cfg_addr, cfg_wdata;
  logic [3:0]  cfg_be;
  ccr_dest_t   kind;
  int          count, n, checks = 0, num_errors = 0;

  ccr_router dut_u (.CLK(clk), .RST_B(rst_b), .IO_REQ(io_req), .IO_WRITE(io_write),
    .IO_ADDR(io_addr), .IO_BE(io_be), .IO_WDATA(io_wdata), .IO_ACK(io_ack), .IO_RDATA(io_rdata),
    .IO_CLAIM(io_claim), .SECONDARY_BUS_VALUE(sec_bus), .SUBORDINATE_BUS_VALUE(sub_bus),
    .PRI_CFG_REQ(pri_req), .GFX_CFG_REQ(gfx_req), .OWN_CFG_REQ(own_req), .IO_PASS_REQ(pass_req),
    .CFG_ABORT(cfg_abort), .CFG_WRITE(cfg_write), .CFG_TYPE1(cfg_type1), .CFG_ADDR(cfg_addr),
    .CFG_BE(cfg_be), .CFG_WDATA(cfg_wdata));
  ccr_target_model target_u (.clk(clk), .rst_b(rst_b), .pri_req(pri_req), .gfx_req(gfx_req),
    .own_req(own_req), .pass_req(pass_req), .abort(cfg_abort), .kind(kind), .count(count));

  // Free-running clock, 4 ns period
  initial begin
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One host I/O access; returns after the target model has seen it
  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    io_req   <= 1'b1;
    io_write <= w;
    io_addr  <= a;
    io_be    <= be;
    io_wdata <= d;
    #1 claim = io_claim;
    @(posedge clk);
    io_req <= 1'b0;
    #1 ack = io_ack;
    @(posedge clk);
    #1;
  endtask

  // Address select write, then one data window access in alternating direction
  task automatic cfg(input logic [31:0] sel, input ccr_dest_t k, input logic [31:0] adr,
                     input logic t1, input logic [3:0] be);
    io(1'b1, CCR_ADDR_SELECT_IO, CCR_ALL_BYTES, sel);
    check(32'(ack), 32'h1);
    n = count;
    dir = ~dir;
    io(dir, CCR_DATA_WINDOW_IO, be, ~sel);
    check(32'(kind), 32'(k));
    check(count, n + 1);
    check(32'(cfg_write), 32'(dir));
    check(32'(cfg_be), 32'(be));
    if (k != CCR_DEST_ABORT) begin
      check(cfg_addr, adr);
      check(32'(cfg_type1), 32'(t1));
    end
    if (dir) check(cfg_wdata, ~sel);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    io(1'b0, CCR_ADDR_SELECT_IO, CCR_ALL_BYTES, 32'h0);
    check(32'(claim), 32'h1);
    check(32'(ack), 32'h1);
    check(io_rdata, CCR_ADDR_RESET);
    cfg(32'h8000_0014, CCR_DEST_OWN, 32'h0000_0814, 1'b0, 4'hf);
    cfg(32'h8000_0808, CCR_DEST_OWN, 32'h0000_1008, 1'b0, 4'h2);
    cfg(32'h8000_0300, CCR_DEST_ABORT, 32'h0, 1'b0, 4'hf);
    cfg(32'h8000_1304, CCR_DEST_PRI, 32'h0000_2304, 1'b0, 4'hc);
    cfg(32'h8000_a000, CCR_DEST_PRI, 32'h8000_0000, 1'b0, 4'hf);
    cfg(32'h8000_a8fc, CCR_DEST_PRI, 32'h0000_00fc, 1'b0, 4'hf);
    cfg(32'h8002_1910, CCR_DEST_PRI, 32'h0002_1911, 1'b1, 4'hf);
    cfg(32'h8004_7800, CCR_DEST_GFX, 32'h8000_0000, 1'b0, 4'hf);
    cfg(32'h8004_8004, CCR_DEST_GFX, 32'h0000_0004, 1'b0, 4'h1);
    cfg(32'h8005_0808, CCR_DEST_GFX, 32'h0005_0809, 1'b1, 4'hf);
    cfg(32'h8006_0000, CCR_DEST_GFX, 32'h0006_0001, 1'b1, 4'hf);
    cfg(32'h8009_f8fc, CCR_DEST_PRI, 32'h0009_f8fd, 1'b1, 4'hf);
    cfg(32'h0004_7800, CCR_DEST_IOPASS, 32'h0000_0cfc, 1'b0, 4'hf);
    @(posedge clk);
    sec_bus <= 8'h02;
    sub_bus <= 8'h02;
    cfg(32'h8002_0000, CCR_DEST_GFX, 32'h0001_0000, 1'b0, 4'hf);
    // Reserved bits, byte pass-through, unmapped port
    io(1'b1, CCR_ADDR_SELECT_IO, CCR_ALL_BYTES, 32'hffff_ffff);
    n = count;
    io(1'b1, CCR_ADDR_SELECT_IO, 4'h1, 32'h0);
    check(32'(kind), 32'(CCR_DEST_IOPASS));
    check(count, n + 1);
    check(32'(claim), 32'h0);
    check(cfg_addr, 32'h0000_0cf8);
    io(1'b0, CCR_ADDR_SELECT_IO, CCR_ALL_BYTES, 32'h0);
    check(io_rdata, 32'h80ff_fffc);
    n = count;
    io(1'b1, 16'h0080, CCR_ALL_BYTES, 32'h8000_0000);
    check(count, n);
    check(32'(ack), 32'h0);
    // Data read right after the address write uses the new value
    @(posedge clk);
    io_req   <= 1'b1;
    io_write <= 1'b1;
    io_addr  <= CCR_ADDR_SELECT_IO;
    io_be    <= CCR_ALL_BYTES;
    io_wdata <= 32'h8000_1000;
    @(posedge clk);
    io_write <= 1'b0;
    io_addr  <= CCR_DATA_WINDOW_IO;
    @(posedge clk);
    io_req <= 1'b0;
    @(posedge clk);
    #1 check(32'(kind), 32'(CCR_DEST_PRI));
    check(cfg_addr, 32'h0000_2000);
    print_verdict();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
